// file: info_descriptor_config_regs.v
// Purpose: Byte-wide configuration registers feeding the info capability
//          descriptor and the serial, maker and product string descriptors.
// Assumes: One writer port shared by EEPROM loader and SMBus engine; string
//          storage at 0x100 upward lives outside, this block only flags it.
// Notes:   I2C mode pins override several fields as read-only views.
`include "info_desc_defines.vh"

// Contract
// - Power code bits 7:4 writable in SMBus mode, reads 1000b in I2C.
// - Power code 0..6 map 1 to 6 W, 7 reserved, top bit means none.
// - Programmed power code is copied into the descriptor power field in SMBus mode; I2C mode gives 1000b.
// - Bits 3:2 drive alt result; I2C mode shows the two result pins.
// - Alt result codes: error, not attempted, failed, configured.
// - Bit 1 is failure info, ignored when power top bit set, zero in I2C.
// - Bit 0 connects the info device; I2C mode follows the connect pin.
// - URL descriptor length byte is two plus twice the URL length.
// - Mode descriptor length byte is two plus twice the mode length.
// - Text lengths reset to zero; zero selects built-in default strings.
// - Serial bytes supply index 1, writable only when custom serial set.
// - Maker bytes supply index 3 when maker length is nonzero.
// - Product bytes supply index 2 when product length is nonzero.
// - Text storage: first string at 0x100, second at 0x1f0.
// - Config-in-progress set on mode entry; upstream held off while set.
module info_descriptor_config_regs (
    input wire clk_in, // Core clock, 25 MHz.
    input wire rst_n_in, // Global reset, active low, asynchronous.
    input wire clk_en_in, // Clock enable; all state holds while low.
    input wire i2c_mode_in, // High selects I2C mode, low SMBus mode.
    input wire config_mode_enter_in, // Pulse: device enters I2C or SMBus mode.
    input wire config_done_in, // Pulse: configuration finished, clears flag.
    input wire custom_serial_allow_in, // High lets serial bytes be written.
    input wire [1:0] alt_result_pins_in, // Alt mode result pins.
    input wire info_connect_pin_in, // Info device connect pin.
    input wire [6:0] maker_text_length_in, // Maker string length in bytes.
    input wire [6:0] product_text_length_in, // Product string length in bytes.
    input wire [7:0] serial_default_in, // Factory serial byte for reset load.
    input wire wr_en_in, // Register write strobe.
    input wire rd_en_in, // Register read strobe.
    input wire [8:0] addr_in, // Register byte address.
    input wire [7:0] wdata_in, // Write data.
    input wire [7:0] str_index_in, // String descriptor index being fetched.
    input wire [5:0] str_byte_in, // Byte position within that string.
    output reg [7:0] rdata_out, // Registered read data.
    output reg [7:0] str_data_out, // Registered string byte.
    output wire str_custom_out, // Selected string comes from registers.
    output reg [3:0] cable_power_code_out, // Descriptor power field.
    output reg [1:0] alt_mode_result_out, // Descriptor alt result field.
    output reg fail_info_out, // Descriptor failure-info field.
    output reg info_device_connect_out, // Info device connected.
    output reg [8:0] url_desc_length_out, // URL descriptor length byte value.
    output reg [8:0] mode_desc_length_out, // Mode descriptor length value.
    output wire url_default_out, // URL string uses built-in default.
    output wire mode_default_out, // Mode string uses built-in default.
    output reg url_store_wr_out, // Write strobe into URL text storage.
    output reg mode_store_wr_out, // Write strobe into mode text storage.
    output reg [7:0] store_offset_out, // Byte offset inside text storage.
    output reg [7:0] store_data_out, // Data for text storage.
    output reg config_in_progress_out, // Configuration active flag.
    output wire upstream_connect_allow_out // Upstream port may connect.
);

    // ======================================================================
    // Decoding helpers
    function in_range;
        input [8:0] a;
        input [8:0] lo;
        input [8:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    reg [3:0] power_code_reg;
    reg [1:0] alt_result_reg;
    reg fail_info_reg;
    reg connect_reg;
    reg [7:0] url_text_length_reg;
    reg [7:0] mode_text_length_reg;
    reg [7:0] serial_text_byte_reg [0:`SERIAL_BYTES-1];
    reg [7:0] maker_text_byte_reg [0:`MAKER_BYTES-1];
    reg [7:0] product_text_byte_reg [0:`PRODUCT_BYTES-1];
    reg serial_loaded_reg;
    reg [5:0] serial_load_idx_reg;

    wire wr_cfg = wr_en_in && (addr_in == `OFS_INFO_DEVICE_CONFIG);
    wire wr_url = wr_en_in && (addr_in == `OFS_URL_TEXT_LENGTH);
    wire wr_mode = wr_en_in && (addr_in == `OFS_MODE_TEXT_LENGTH);
    wire [8:0] serial_rel = addr_in - `OFS_SERIAL_FIRST;
    wire [8:0] maker_rel = addr_in - `OFS_MAKER_FIRST;
    wire [8:0] product_rel = addr_in - `OFS_PRODUCT_FIRST;
    wire hit_serial = in_range(addr_in, `OFS_SERIAL_FIRST, `OFS_SERIAL_LAST);
    wire hit_maker = in_range(addr_in, `OFS_MAKER_FIRST, `OFS_MAKER_LAST);
    wire hit_product =
        in_range(addr_in, `OFS_PRODUCT_FIRST, `OFS_PRODUCT_LAST);

    // ======================================================================
    // Configuration register fields.
    // In I2C mode the pin-driven fields are views, so writes are dropped.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            power_code_reg <= `CFG_POWER_RESET;
            alt_result_reg <= `CFG_ALT_RESET;
            fail_info_reg <= 1'b0;
            connect_reg <= 1'b0;
        end
        else if (clk_en_in && wr_cfg && !i2c_mode_in)
        begin
            power_code_reg <= wdata_in[`CFG_POWER_MSB:`CFG_POWER_LSB];
            alt_result_reg <= wdata_in[`CFG_ALT_MSB:`CFG_ALT_LSB];
            fail_info_reg <= wdata_in[`CFG_FAIL_BIT];
            connect_reg <= wdata_in[`CFG_CONNECT_BIT];
        end
    end

    // ======================================================================
    // Effective field values as seen by software and the descriptor.
    reg [3:0] eff_power;
    reg [1:0] eff_alt;
    reg eff_fail;
    reg eff_connect;
    always @*
    begin
        eff_power = i2c_mode_in ? `CFG_POWER_I2C : power_code_reg;
        eff_alt = i2c_mode_in ? alt_result_pins_in : alt_result_reg;
        eff_fail = i2c_mode_in ? 1'b0 : fail_info_reg;
        eff_connect = i2c_mode_in ? info_connect_pin_in : connect_reg;
    end

    // ======================================================================
    // Text lengths; values above 120 are the writer's fault and kept as is.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            url_text_length_reg <= `TEXT_LENGTH_RESET;
            mode_text_length_reg <= `TEXT_LENGTH_RESET;
        end
        else if (clk_en_in)
        begin
            if (wr_url)
                url_text_length_reg <= wdata_in;
            if (wr_mode)
                mode_text_length_reg <= wdata_in;
        end
    end

    // ======================================================================
    // String byte arrays. Serial bytes load the factory value one per cycle
    // after reset, since an async reset may only take constants.
    genvar g;
    generate
        for (g = 0; g < `SERIAL_BYTES; g = g + 1)
        begin : gen_serial
            always @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    serial_text_byte_reg[g] <= `TEXT_BYTE_RESET;
                else if (clk_en_in)
                begin
                    if (!serial_loaded_reg && serial_load_idx_reg[4:0] == g)
                        serial_text_byte_reg[g] <= serial_default_in;
                    else if (wr_en_in && hit_serial &&
                             custom_serial_allow_in &&
                             serial_rel[4:0] == g)
                        serial_text_byte_reg[g] <= wdata_in;
                end
            end
        end
        for (g = 0; g < `MAKER_BYTES; g = g + 1)
        begin : gen_text
            always @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    maker_text_byte_reg[g] <= `TEXT_BYTE_RESET;
                    product_text_byte_reg[g] <= `TEXT_BYTE_RESET;
                end
                else if (clk_en_in && wr_en_in)
                begin
                    if (hit_maker && maker_rel[5:0] == g)
                        maker_text_byte_reg[g] <= wdata_in;
                    if (hit_product && product_rel[5:0] == g)
                        product_text_byte_reg[g] <= wdata_in;
                end
            end
        end
    endgenerate

    // Factory serial load walker.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            serial_loaded_reg <= 1'b0;
            serial_load_idx_reg <= 6'h00;
        end
        else if (clk_en_in && !serial_loaded_reg)
        begin
            serial_load_idx_reg <= serial_load_idx_reg + 6'h01;
            if (serial_load_idx_reg[4:0] == 5'h1f)
                serial_loaded_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Configuration-in-progress flag; entry wins over a same-cycle finish.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            config_in_progress_out <= 1'b0;
        else if (clk_en_in)
        begin
            if (config_mode_enter_in)
                config_in_progress_out <= 1'b1;
            else if (config_done_in)
                config_in_progress_out <= 1'b0;
        end
    end
    assign upstream_connect_allow_out = !config_in_progress_out;

    // ======================================================================
    // Descriptor-facing outputs, registered.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cable_power_code_out <= `CFG_POWER_RESET;
            alt_mode_result_out <= `CFG_ALT_RESET;
            fail_info_out <= 1'b0;
            info_device_connect_out <= 1'b0;
            url_desc_length_out <= `DESC_LENGTH_BASE;
            mode_desc_length_out <= `DESC_LENGTH_BASE;
        end
        else if (clk_en_in)
        begin
            // Codes 0..6 are watts, 7 reserved, 1xxx no power; passed raw.
            cable_power_code_out <= eff_power;
            alt_mode_result_out <= eff_alt;
            // Failure info is meaningless when no cable power is needed.
            fail_info_out <= eff_fail && !eff_power[3];
            info_device_connect_out <= eff_connect;
            url_desc_length_out <= `DESC_LENGTH_BASE +
                {url_text_length_reg, 1'b0};
            mode_desc_length_out <= `DESC_LENGTH_BASE +
                {mode_text_length_reg, 1'b0};
        end
    end
    assign url_default_out = (url_text_length_reg == 8'h00);
    assign mode_default_out = (mode_text_length_reg == 8'h00);

    // ======================================================================
    // Text storage write strobes; storage itself is outside this block.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            url_store_wr_out <= 1'b0;
            mode_store_wr_out <= 1'b0;
            store_offset_out <= 8'h00;
            store_data_out <= 8'h00;
        end
        else if (clk_en_in)
        begin
            url_store_wr_out <= wr_en_in && addr_in >= `OFS_URL_TEXT_STORE &&
                addr_in < `OFS_MODE_TEXT_STORE;
            mode_store_wr_out <= wr_en_in &&
                addr_in >= `OFS_MODE_TEXT_STORE;
            store_offset_out <= (addr_in >= `OFS_MODE_TEXT_STORE) ?
                {4'h0, addr_in[3:0]} : addr_in[7:0];
            store_data_out <= wdata_in;
        end
    end

    // ======================================================================
    // Register read-back; text storage is write-only and reads zero.
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 8'h00;
        else if (clk_en_in && rd_en_in)
        begin
            if (addr_in == `OFS_INFO_DEVICE_CONFIG)
                rdata_out <= {eff_power, eff_alt, eff_fail, eff_connect};
            else if (addr_in == `OFS_URL_TEXT_LENGTH)
                rdata_out <= url_text_length_reg;
            else if (addr_in == `OFS_MODE_TEXT_LENGTH)
                rdata_out <= mode_text_length_reg;
            else if (hit_serial)
                rdata_out <= serial_text_byte_reg[serial_rel[4:0]];
            else if (hit_maker)
                rdata_out <= maker_text_byte_reg[maker_rel[5:0]];
            else if (hit_product)
                rdata_out <= product_text_byte_reg[product_rel[5:0]];
            else
                rdata_out <= 8'h00;
        end
    end

    // ======================================================================
    // String descriptor byte fetch. Maker and product bytes past their length, and serial bytes past 31, read 0.
    wire [6:0] pos = {1'b0, str_byte_in};
    assign str_custom_out = (str_index_in == 8'h01) ||
        (str_index_in == 8'h03 && maker_text_length_in != 7'h00) ||
        (str_index_in == 8'h02 && product_text_length_in != 7'h00);
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            str_data_out <= 8'h00;
        else if (clk_en_in)
        begin
            case (str_index_in)
                8'h01:
                    str_data_out <= str_byte_in[5] ? 8'h00 :
                        serial_text_byte_reg[str_byte_in[4:0]];
                8'h02:
                    str_data_out <= (pos < product_text_length_in) ?
                        product_text_byte_reg[str_byte_in] : 8'h00;
                8'h03:
                    str_data_out <= (pos < maker_text_length_in) ?
                        maker_text_byte_reg[str_byte_in] : 8'h00;
                default:
                    str_data_out <= 8'h00;
            endcase
        end
    end

endmodule

// file: info_desc_defines.vh
// Purpose: Offsets, field positions, reset values for the info descriptor
//          configuration register bank.
// Assumes: Byte-wide register port with a 9-bit byte address.
// Notes:   Included by info_descriptor_config_regs.v only.
`ifndef INFO_DESC_DEFINES_VH
`define INFO_DESC_DEFINES_VH

// ==========================================================================
// Register offsets
`define OFS_INFO_DEVICE_CONFIG 9'h02b
`define OFS_URL_TEXT_LENGTH 9'h02c
`define OFS_MODE_TEXT_LENGTH 9'h02d
`define OFS_SERIAL_FIRST 9'h030
`define OFS_SERIAL_LAST 9'h04f
`define OFS_MAKER_FIRST 9'h050
`define OFS_MAKER_LAST 9'h08f
`define OFS_PRODUCT_FIRST 9'h090
`define OFS_PRODUCT_LAST 9'h0cf
`define OFS_URL_TEXT_STORE 9'h100
`define OFS_MODE_TEXT_STORE 9'h1f0

// ==========================================================================
// Array sizes
`define SERIAL_BYTES 32
`define MAKER_BYTES 64
`define PRODUCT_BYTES 64

// ==========================================================================
// Field positions and values
`define CFG_POWER_MSB 7
`define CFG_POWER_LSB 4
`define CFG_POWER_NONE_BIT 7
`define CFG_ALT_MSB 3
`define CFG_ALT_LSB 2
`define CFG_FAIL_BIT 1
`define CFG_CONNECT_BIT 0
`define CFG_POWER_I2C 4'h8
`define CFG_POWER_RESET 4'h8
`define CFG_ALT_RESET 2'h0
`define TEXT_LENGTH_RESET 8'h00
`define TEXT_BYTE_RESET 8'h00
`define DESC_LENGTH_BASE 9'h002
`define POWER_CODE_RESERVED 4'h7
`define ALT_UNSPECIFIED_ERROR 2'h0
`define ALT_NOT_ATTEMPTED 2'h1
`define ALT_ATTEMPT_FAILED 2'h2
`define ALT_CONFIGURED 2'h3

`endif

// file: info_desc_cfg_writer.sv
// Purpose: Model of the SMBus host or EEPROM that programs the bank.
// Assumes: Tasks are entered 1 ns after a rising clock edge.
// Notes: One strobe per byte; the bank takes it at the next rising edge.
module info_desc_cfg_writer (
    input logic clk_in, // Core clock.
    input logic [7:0] rdata_in, // Read data from the bank.
    output logic wr_en_out, // Write strobe.
    output logic rd_en_out, // Read strobe.
    output logic [8:0] addr_out, // Byte address.
    output logic [7:0] wdata_out // Write data.
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Bus idles with both strobes low.
    initial
    begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 9'h000;
        wdata_out = 8'h00;
    end
    // Callers keep lengths at 120 or less and text in UTF-16LE order.
    // Data is inverted after release so stale bytes never look valid.
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = d;
        wr_en_out = 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wdata_out <= ~d;
        #1;
    endtask
    // Read data is registered at the taking edge, so it is settled here.
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        addr_out = a;
        rd_en_out = 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        #1 d = rdata_in;
    endtask
endmodule

// file: info_desc_checker_properties.sv
// Purpose: Concurrent checks on the info descriptor register bank.
// Assumes: Bound to the bank; descriptor fields lag a write by two edges.
// Notes: I2C views are checked after a full enabled I2C edge.
module info_desc_props (
    input logic clk_in, // Clock.
    input logic rst_n_in, // Reset, active low.
    input logic clk_en_in, // Clock enable.
    input logic i2c_mode_in, // I2C mode.
    input logic config_mode_enter_in, // Mode entry pulse.
    input logic [1:0] alt_result_pins_in, // Alt result pins.
    input logic info_connect_pin_in, // Connect pin.
    input logic wr_en_in, // Write strobe.
    input logic [8:0] addr_in, // Address.
    input logic [7:0] wdata_in, // Write data.
    input logic [3:0] cable_power_code_out, // Power field.
    input logic [1:0] alt_mode_result_out, // Alt field.
    input logic fail_info_out, // Failure info.
    input logic info_device_connect_out, // Connected.
    input logic [8:0] url_desc_length_out, // URL length byte.
    input logic [8:0] mode_desc_length_out, // Mode length byte.
    input logic url_default_out, // URL default.
    input logic url_store_wr_out, // URL store strobe.
    input logic mode_store_wr_out, // Mode store strobe.
    input logic [7:0] store_offset_out, // Store offset.
    input logic config_in_progress_out, // Config flag.
    input logic upstream_connect_allow_out // Upstream allowed.
);
    // ==========================================================
    // Remembers an enabled I2C edge; cleared by reset.
    logic i2c_seen_reg;
    always_ff @(posedge clk_in or negedge rst_n_in)
        i2c_seen_reg <= rst_n_in && i2c_mode_in && clk_en_in;
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    AST_CFG_WRITE: assert property (
        wr_en_in && clk_en_in && addr_in == 9'h02b && !i2c_mode_in |=> ##1
        {cable_power_code_out, alt_mode_result_out, 1'b0,
        info_device_connect_out} == ($past(wdata_in, 2) & 8'hfd))
        else $error("descriptor fields differ from write");
    AST_FAIL_WRITE: assert property (
        wr_en_in && clk_en_in && addr_in == 9'h02b && !i2c_mode_in |=> ##1
        fail_info_out == (($past(wdata_in, 2) & 8'h82) == 8'h02))
        else $error("failure info not masked by power bit");
    AST_I2C_FIXED: assert property (i2c_seen_reg |->
        cable_power_code_out == 4'h8 && !fail_info_out)
        else $error("fixed I2C fields wrong");
    AST_I2C_PINS: assert property (i2c_seen_reg |->
        alt_mode_result_out == $past(alt_result_pins_in) &&
        info_device_connect_out == $past(info_connect_pin_in))
        else $error("I2C fields do not follow pins");
    AST_URL_LEN: assert property (
        wr_en_in && clk_en_in && addr_in == 9'h02c |=>
        url_default_out == ($past(wdata_in) == 8'h00) ##1
        url_desc_length_out == {$past(wdata_in, 2), 1'b0} + 9'h002)
        else $error("URL length byte wrong");
    AST_MODE_LEN: assert property (
        wr_en_in && clk_en_in && addr_in == 9'h02d |=> ##1
        mode_desc_length_out == {$past(wdata_in, 2), 1'b0} + 9'h002)
        else $error("mode length byte wrong");
    AST_STORE_URL: assert property (
        wr_en_in && clk_en_in && addr_in[8] && addr_in < 9'h1f0 |=>
        url_store_wr_out && !mode_store_wr_out &&
        {1'b1, store_offset_out} == $past(addr_in))
        else $error("URL store strobe wrong");
    AST_STORE_MODE: assert property (
        wr_en_in && clk_en_in && addr_in >= 9'h1f0 |=>
        mode_store_wr_out && !url_store_wr_out &&
        {1'b0, store_offset_out} == $past(addr_in) - 9'h1f0)
        else $error("mode store strobe wrong");
    AST_CFG_FLAG: assert property (config_mode_enter_in && clk_en_in |=>
        config_in_progress_out && !upstream_connect_allow_out)
        else $error("config flag does not hold off upstream");
    cover property (i2c_seen_reg && alt_mode_result_out == 2'h2);
    cover property (mode_store_wr_out);
    cover property (config_in_progress_out);
endmodule

// file: tb_info_descriptor_config_regs.sv
// Purpose: Self-checking bench for the info descriptor register bank.
// Assumes: Inputs move 1 ns after a rising edge; the writer owns the bus.
// Notes: Serial defaults load for 32 cycles after reset release.
module tb_info_descriptor_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_n_in, clk_en_in, i2c_mode_in, config_mode_enter_in;
    logic config_done_in, custom_serial_allow_in, info_connect_pin_in;
    logic wr_en_in, rd_en_in, str_custom_out, fail_info_out;
    logic info_device_connect_out, url_default_out, mode_default_out;
    logic url_store_wr_out, mode_store_wr_out, config_in_progress_out;
    logic upstream_connect_allow_out;
    logic [1:0] alt_result_pins_in, alt_mode_result_out;
    logic [3:0] cable_power_code_out;
    logic [6:0] maker_text_length_in, product_text_length_in;
    logic [8:0] addr_in, url_desc_length_out, mode_desc_length_out;
    logic [7:0] serial_default_in, wdata_in, str_index_in, rdata_out, rd_v;
    logic [7:0] str_data_out, store_offset_out, store_data_out, fld;
    logic [5:0] str_byte_in;
    logic [7:0] str_exp [1:3] = '{8'h11, 8'h42, 8'h41};
    int num_errors = 0;
    int n_checks = 0;
    int i;
    // Descriptor fields packed as the configuration byte lays them out.
    assign fld = {cable_power_code_out, alt_mode_result_out, fail_info_out,
        info_device_connect_out};
    info_descriptor_config_regs info_descriptor_config_regs_i (
        .clk_in, .rst_n_in, .clk_en_in, .i2c_mode_in, .config_mode_enter_in,
        .config_done_in, .custom_serial_allow_in, .alt_result_pins_in,
        .info_connect_pin_in, .maker_text_length_in, .product_text_length_in,
        .serial_default_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in,
        .str_index_in, .str_byte_in, .rdata_out, .str_data_out,
        .str_custom_out, .cable_power_code_out, .alt_mode_result_out,
        .fail_info_out, .info_device_connect_out, .url_desc_length_out,
        .mode_desc_length_out, .url_default_out, .mode_default_out,
        .url_store_wr_out, .mode_store_wr_out, .store_offset_out,
        .store_data_out, .config_in_progress_out, .upstream_connect_allow_out);
    info_desc_cfg_writer info_desc_cfg_writer_i (.clk_in, .rdata_in(rdata_out),
        .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in),
        .wdata_out(wdata_in));
    // ==========================================================
    // Shared comparison, cycle and bus helpers.
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        info_desc_cfg_writer_i.wr(a, d);
    endtask
    task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
        info_desc_cfg_writer_i.rd(a, rd_v);
        chk("rdata", exp, rd_v);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // 25 MHz clock; the watchdog cuts a hang short as a mismatch.
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish;
    end
    // ==========================================================
    // Main sequence: reset values, field codes, modes, strings, storage.
    initial
    begin
        rst_n_in = 1'b0;
        clk_en_in = 1'b1;
        serial_default_in = 8'h5a;
        {i2c_mode_in, config_mode_enter_in, config_done_in,
            custom_serial_allow_in, alt_result_pins_in, info_connect_pin_in,
            maker_text_length_in, product_text_length_in, str_index_in,
            str_byte_in} = '0;
        repeat (2) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        cyc(33);
        rdchk(9'h02b, 8'h80);
        rdchk(9'h02c, 8'h00);
        rdchk(9'h02d, 8'h00);
        chk("dflt", 2'b11, {url_default_out, mode_default_out});
        rdchk(9'h04f, 8'h5a);
        rdchk(9'h050, 8'h00);
        // Every power and alt code, with failure info requested each time.
        for (i = 0; i < 16; i++)
        begin
            wr(9'h02b, {i[3:0], i[1:0], 2'b11});
            rdchk(9'h02b, {i[3:0], i[1:0], 2'b11});
            chk("fld", {i[3:0], i[1:0], ~i[3], 1'b1}, fld);
        end
        wr(9'h02c, 8'h78);
        wr(9'h02d, 8'h01);
        wr(9'h02b, 8'h3c);
        chk("len", 18'h1e404, {url_desc_length_out, mode_desc_length_out});
        chk("dflt", 2'b00, {url_default_out, mode_default_out});
        wr(9'h02d, 8'h00);
        chk("dflt", 1'b1, mode_default_out);
        // I2C mode: pins drive the fields and writes are dropped.
        i2c_mode_in = 1'b1;
        alt_result_pins_in = 2'h2;
        info_connect_pin_in = 1'b1;
        wr(9'h02b, 8'h53);
        chk("fld", 8'h89, fld);
        alt_result_pins_in = 2'h1;
        info_connect_pin_in = 1'b0;
        info_desc_cfg_writer_i.rd(9'h02b, rd_v);
        chk("fld", 8'h84, fld);
        chk("rdata", 5'h10, {rd_v[7:4], rd_v[1]});
        i2c_mode_in = 1'b0;
        rdchk(9'h02b, 8'h3c);
        chk("fld", 8'h3c, fld);
        // Serial bytes stay locked until custom serial is allowed.
        wr(9'h030, 8'h11);
        rdchk(9'h030, 8'h5a);
        custom_serial_allow_in = 1'b1;
        wr(9'h030, 8'h11);
        wr(9'h050, 8'h41);
        wr(9'h090, 8'h42);
        str_index_in = 8'h02;
        cyc(1);
        chk("cust", 1'b0, str_custom_out);
        maker_text_length_in = 7'h02;
        product_text_length_in = 7'h02;
        for (i = 1; i < 4; i++)
        begin
            str_index_in = i[7:0];
            cyc(1);
            chk("str", {1'b1, str_exp[i]}, {str_custom_out, str_data_out});
        end
        // Text storage is write only and split at 0x1f0.
        wr(9'h105, 8'hab);
        chk("st", 18'h205ab, {url_store_wr_out, mode_store_wr_out,
            store_offset_out, store_data_out});
        wr(9'h1f3, 8'hcd);
        chk("st", 18'h103cd, {url_store_wr_out, mode_store_wr_out,
            store_offset_out, store_data_out});
        rdchk(9'h105, 8'h00);
        rdchk(9'h0d0, 8'h00);
        config_mode_enter_in = 1'b1;
        cyc(1);
        config_mode_enter_in = 1'b0;
        chk("cfg", 2'b10, {config_in_progress_out, upstream_connect_allow_out});
        config_done_in = 1'b1;
        cyc(1);
        config_done_in = 1'b0;
        chk("cfg", 2'b01, {config_in_progress_out, upstream_connect_allow_out});
        tally_and_finish;
    end
endmodule
bind info_descriptor_config_regs info_desc_props info_desc_props_i (
    .clk_in, .rst_n_in, .clk_en_in, .i2c_mode_in, .config_mode_enter_in,
    .alt_result_pins_in, .info_connect_pin_in, .wr_en_in, .addr_in,
    .wdata_in, .cable_power_code_out, .alt_mode_result_out, .fail_info_out,
    .info_device_connect_out, .url_desc_length_out, .mode_desc_length_out,
    .url_default_out, .url_store_wr_out, .mode_store_wr_out,
    .store_offset_out, .config_in_progress_out, .upstream_connect_allow_out);
